// >>> rtl/autobaud_serial_port.sv
// Autobaud full duplex serial port of a datalogger
//
// What this block does
// R1 - Seven-bit characters shifted onto the line least significant bit first.
// R2 - Transmitter sends eight data bits, eighth always zero, no parity.
// R3 - Receiver takes eight data bits and discards the eighth.
// R4 - Frame is one space start bit, data, one mark stop bit.
// R5 - Line idles marking between characters.
// R6 - Logic pin drives high for spacing, low for marking.
// R7 - Four bit rates: 300, 1200, 9600 and 76800.
// R8 - On wake, port adopts the terminal's bit rate.
// R9 - Transmit and receive run independently, full duplex.
// R10 - Terminal uses 300, 1200 or 9600, 8 bits, 1 stop, no parity; the port also hunts and locks at 76800.
// R11 - Terminal must not send eight bits plus parity.
// R12 - Wait about forty seconds for carriage returns, else hang up.
// R13 - After lock send carriage return, line feed, asterisk, then command.
// R14 - Lock on first rate that decodes carriage return correctly.
// R15 - Sample bits mid-cell by oversampling; drop characters with bad stop.
`default_nettype none
module autobaud_serial_port
  import serial_port_pkg::*;
#(
  parameter longint unsigned wait_cycles = wait_cycles_full
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Session control
  input wire logic wake,
  output logic session_open,
  output logic hangup,
  output rate_sel_t rate_locked,
  // Serial pins, inverted logic levels
  input wire logic rxd_pin,
  output logic txd_pin,
  // Transmit stream
  input wire logic [6:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // Receive stream
  output logic [6:0] rx_data,
  output logic rx_valid
);
  // ==========================================================
  // Pin synchroniser
  logic rx_meta_reg;
  logic rx_sync_reg;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_meta_reg <= 1'b0;
      rx_sync_reg <= 1'b0;
    end
    else
    begin
      rx_meta_reg <= rxd_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end
  // Low on the pin is mark
  wire line_mark = !rx_sync_reg; // R6

  // ==========================================================
  // Receiver lanes, one per rate, so hunting tests all at once
  rx_char_t lane_char [rate_count];
  logic [rate_count-1:0] lane_valid;
  logic [rate_count-1:0] lane_cr;
  session_state_t state_reg;
  session_state_t state_next;
  rate_sel_t rate_reg;

  genvar g;
  generate
    for (g = 0; g < rate_count; g++)
    begin : lanes
      serial_rx_lane lane (
        .mclk(mclk),
        .nrst(nrst),
        .line_mark(line_mark),
        .rate(rate_sel_t'(g)), // R7
        .rx_char(lane_char[g]),
        .rx_valid(lane_valid[g])
      );
      assign lane_cr[g] = lane_valid[g] && lane_char[g].framing_ok &&
        (lane_char[g].code == cr_code[6:0]); // R14
    end
  endgenerate

  // Lowest rate wins on a tie; slow lanes finish last, so this
  // is the first rate to decode it cleanly
  logic [1:0] hit_idx;
  always_comb
  begin
    hit_idx = 2'h0;
    for (int i = rate_count - 1; i >= 0; i--)
      if (lane_cr[i])
        hit_idx = 2'(i); // R14
  end
  wire any_cr = |lane_cr;

  // ==========================================================
  // Session sequencer
  logic [63:0] wait_reg;
  logic [1:0] prompt_reg;
  wire timed_out = (wait_reg >= wait_cycles - 64'h1);
  wire tx_busy;
  wire prompt_done;

  assign prompt_done = (prompt_reg == 2'h3) && !tx_busy;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      st_asleep: if (wake) state_next = st_hunt;
      st_hunt:
        if (any_cr) state_next = st_prompt; // R8
        else if (timed_out) state_next = st_hangup; // R12
      st_prompt: if (prompt_done) state_next = st_command; // R13
      st_command: if (wake) state_next = st_command;
      st_hangup: state_next = st_asleep;
      default: state_next = st_asleep;
    endcase
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg <= st_asleep;
      rate_reg <= rate_300;
      wait_reg <= 64'h0;
    end
    else
    begin
      state_reg <= state_next;
      wait_reg <= (state_reg == st_hunt) ? wait_reg + 64'h1 : 64'h0; // R12
      if (state_reg == st_hunt && any_cr)
        rate_reg <= hit_idx; // R8
    end
  end

  // ==========================================================
  // Transmitter
  logic [15:0] tx_div_reg;
  logic [3:0] tx_tick_reg;
  logic [3:0] tx_bit_reg;
  logic [9:0] tx_frame_reg;
  logic tx_busy_reg;

  wire tx_os_tick = (tx_div_reg == 16'h0000);
  wire tx_bit_end = tx_os_tick && (tx_tick_reg == 4'(os_rate - 1));
  wire in_prompt = (state_reg == st_prompt);
  wire [7:0] prompt_char = (prompt_reg == 2'h0) ? cr_code :
    (prompt_reg == 2'h1) ? lf_code : star_code;
  wire user_send = (state_reg == st_command) && tx_valid;
  wire prompt_send = in_prompt && (prompt_reg != 2'h3);
  wire tx_start = !tx_busy_reg && (user_send || prompt_send);
  // Eighth bit forced to zero
  wire [7:0] tx_byte = prompt_send ? {1'b0, prompt_char[6:0]} :
    {1'b0, tx_data & char_mask}; // R2

  assign tx_busy = tx_busy_reg;
  assign tx_ready = !tx_busy_reg && (state_reg == st_command); // R9

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      tx_div_reg <= 16'h0000;
      tx_tick_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_frame_reg <= 10'h3ff;
      tx_busy_reg <= 1'b0;
      prompt_reg <= 2'h0;
    end
    else
    begin
      tx_div_reg <= (tx_os_tick || tx_start) ?
        os_divisor(rate_reg) - 16'h0001 : tx_div_reg - 16'h0001;
      if (state_reg != st_prompt)
        prompt_reg <= 2'h0;
      if (tx_start)
      begin
        tx_busy_reg <= 1'b1;
        tx_tick_reg <= 4'h0;
        tx_bit_reg <= 4'h0;
        // Stop mark, data LSB first, start space
        tx_frame_reg <= {1'b1, tx_byte, 1'b0}; // R1 R4
        if (prompt_send)
          prompt_reg <= prompt_reg + 2'h1; // R13
      end
      else if (tx_busy_reg && tx_os_tick)
      begin
        tx_tick_reg <= tx_tick_reg + 4'h1;
        if (tx_bit_end)
        begin
          // Shift in mark so idle follows stop
          tx_frame_reg <= {1'b1, tx_frame_reg[9:1]}; // R5
          tx_bit_reg <= tx_bit_reg + 4'h1;
          if (tx_bit_reg == 4'(data_bits + 1))
            tx_busy_reg <= 1'b0;
        end
      end
    end
  end

  // Pin high means space
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      txd_pin <= 1'b0;
    else
      txd_pin <= !tx_frame_reg[0]; // R6
  end

  // ==========================================================
  // Outputs; receive runs alongside transmit
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rx_data <= 7'h00;
      rx_valid <= 1'b0;
    end
    else
    begin
      rx_valid <= (state_reg == st_command) && lane_valid[rate_reg] &&
        lane_char[rate_reg].framing_ok; // R9 R15
      rx_data <= lane_char[rate_reg].code; // R3
    end
  end

  assign session_open = (state_reg == st_command);
  assign hangup = (state_reg == st_hangup);
  assign rate_locked = rate_reg;
endmodule // autobaud_serial_port
`default_nettype wire

// >>> inc/serial_port_pkg.sv
// Package of constants and types for the autobaud serial port
`default_nettype none
package serial_port_pkg;
  localparam int unsigned clk_hz = 100_000_000;
  localparam int unsigned os_rate = 16;
  localparam int unsigned rate_count = 4;
  localparam logic [7:0] cr_code = 8'h0d;
  localparam logic [7:0] lf_code = 8'h0a;
  localparam logic [7:0] star_code = 8'h2a;
  localparam logic [6:0] char_mask = 7'h7f;
  localparam int unsigned data_bits = 8;
  localparam int unsigned mid_tick = os_rate / 2;
  localparam int unsigned wait_seconds = 40;
  localparam longint unsigned wait_cycles_full =
    longint'(wait_seconds) * longint'(clk_hz);

  // Bit rates and derived oversample divisors
  localparam int unsigned baud_300 = 300;
  localparam int unsigned baud_1200 = 1200;
  localparam int unsigned baud_9600 = 9600;
  localparam int unsigned baud_76800 = 76800;

  typedef logic [1:0] rate_sel_t;
  localparam rate_sel_t rate_300 = 2'h0;
  localparam rate_sel_t rate_1200 = 2'h1;
  localparam rate_sel_t rate_9600 = 2'h2;
  localparam rate_sel_t rate_76800 = 2'h3;

  function automatic logic [15:0] os_divisor(input rate_sel_t sel);
    unique case (sel)
      rate_300: os_divisor = 16'(clk_hz / (baud_300 * os_rate));
      rate_1200: os_divisor = 16'(clk_hz / (baud_1200 * os_rate));
      rate_9600: os_divisor = 16'(clk_hz / (baud_9600 * os_rate));
      default: os_divisor = 16'(clk_hz / (baud_76800 * os_rate));
    endcase
  endfunction

  // Received character with its framing result
  typedef struct packed {
    logic [6:0] code;
    logic framing_ok;
  } rx_char_t;

  typedef enum logic [4:0] {
    st_asleep = 5'h01,
    st_hunt = 5'h02,
    st_prompt = 5'h04,
    st_command = 5'h08,
    st_hangup = 5'h10
  } session_state_t;
endpackage
`default_nettype wire

// >>> rtl/serial_rx_lane.sv
// One oversampling receiver lane at a fixed bit rate
`default_nettype none
module serial_rx_lane
  import serial_port_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Line and rate
  input wire logic line_mark,
  input wire rate_sel_t rate,
  // Received character
  output rx_char_t rx_char,
  output logic rx_valid
);
  logic [15:0] div_reg;
  logic [3:0] tick_reg;
  logic [3:0] bit_reg;
  logic busy_reg;
  logic [7:0] shift_reg;
  logic valid_reg;
  rx_char_t char_reg;

  wire os_tick = (div_reg == 16'h0000);
  wire mid_point = os_tick && (tick_reg == 4'(mid_tick));
  wire start_seen = !busy_reg && !line_mark;
  wire last_bit = (bit_reg == 4'(data_bits + 1));

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_reg <= 16'h0000;
      tick_reg <= 4'h0;
      bit_reg <= 4'h0;
      busy_reg <= 1'b0;
      shift_reg <= 8'h00;
      valid_reg <= 1'b0;
      char_reg <= '0;
    end
    else
    begin
      valid_reg <= 1'b0;
      div_reg <= os_tick ? os_divisor(rate) - 16'h0001 : div_reg - 16'h0001;
      if (start_seen)
      begin
        busy_reg <= 1'b1;
        tick_reg <= 4'h0;
        bit_reg <= 4'h0;
      end
      else if (busy_reg && os_tick)
      begin
        tick_reg <= tick_reg + 4'h1;
        if (mid_point) // R15
        begin
          bit_reg <= bit_reg + 4'h1;
          if (bit_reg == 4'h0 && line_mark)
            busy_reg <= 1'b0; // False start glitch
          else if (last_bit)
          begin
            busy_reg <= 1'b0;
            valid_reg <= 1'b1;
            // Eighth bit dropped, stop must be mark
            char_reg <= '{code: shift_reg[6:0], framing_ok: line_mark}; // R3 R15
          end
          else if (bit_reg != 4'h0)
            shift_reg <= {!line_mark ? 1'b0 : 1'b1, shift_reg[7:1]}; // R1
        end
      end
    end
  end

  assign rx_char = char_reg;
  assign rx_valid = valid_reg;
endmodule // serial_rx_lane
`default_nettype wire

// >>> sim/autobaud_serial_port_sva.sv
// Checker for the autobaud serial port
`default_nettype none
module autobaud_serial_port_sva
  import serial_port_pkg::*;
#(
  parameter longint unsigned wait_cycles = 2000
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Session
  input wire logic wake,
  input wire logic session_open,
  input wire logic hangup,
  input wire rate_sel_t rate_locked,
  // Pins and streams
  input wire logic rxd_pin,
  input wire logic txd_pin,
  input wire logic [6:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [6:0] rx_data,
  input wire logic rx_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic [31:0] wake_cnt_reg;
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) wake_cnt_reg <= '0;
    else if (wake) wake_cnt_reg <= '0;
    else wake_cnt_reg <= wake_cnt_reg + 32'h1;
  sequence s_take;
    tx_valid && tx_ready;
  endsequence
  sequence s_start;
    txd_pin [*8];
  endsequence
  // Pin is registered after the frame load, so start shows one edge later
  a_start_space: assert property (s_take |=> ##1 s_start)
    else $error("start bit not high after take");
  a_busy_frame: assert property (s_take |=> !tx_ready [*8])
    else $error("ready during frame");
  a_ready_cmd: assert property (tx_ready |-> session_open)
    else $error("ready outside command state");
  a_open_holds: assert property (session_open |=> session_open)
    else $error("session closed");
  a_rate_hold: assert property (session_open |=> $stable(rate_locked))
    else $error("rate moved in session");
  a_rx_pulse: assert property (rx_valid |=> !rx_valid)
    else $error("rx valid too long");
  a_rx_open: assert property (rx_valid |-> session_open)
    else $error("rx outside session");
  a_hang_pulse: assert property (hangup |=> !hangup && !session_open)
    else $error("hangup not a pulse");
  a_hang_time: assert property (hangup |->
    wake_cnt_reg + 32'h4 >= 32'(wait_cycles))
    else $error("hangup too early");
endmodule // autobaud_serial_port_sva
bind autobaud_serial_port autobaud_serial_port_sva #(
  .wait_cycles(wait_cycles)
) i_autobaud_serial_port_sva (.mclk(mclk), .nrst(nrst), .wake(wake),
  .session_open(session_open), .hangup(hangup), .rate_locked(rate_locked),
  .rxd_pin(rxd_pin), .txd_pin(txd_pin), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
  .rx_valid(rx_valid));
`default_nettype wire

// >>> sim/serial_terminal.sv
// Terminal model on the far side of the serial pins
`default_nettype none
module serial_terminal
#(
  parameter int bit_cycles = 1302
)
(
  input wire logic mclk,
  input wire logic from_dev,
  output logic to_dev,
  output logic [8:0] got,
  output logic got_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    to_dev = 0;
    got = '0;
    got_valid = 0;
  end
  // ==========
  // Pin high is space, low is mark
  task automatic send(input logic [7:0] b, input bit bad_stop);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge mclk);
      #1 to_dev = !f[i] || (bad_stop && i == 9);
      // Short bad stop so its tail cannot pass as a start
      repeat (bad_stop && i == 9 ? bit_cycles * 5 / 8 : bit_cycles - 1)
        @(posedge mclk);
    end
    #1 to_dev = 0;
  endtask
  // Decode mid-cell; got holds stop value over eight data bits
  always
  begin
    @(negedge mclk);
    got_valid = 0;
    if (from_dev)
    begin
      repeat (bit_cycles / 2) @(negedge mclk);
      for (int i = 0; i < 9; i++)
      begin
        repeat (bit_cycles) @(negedge mclk);
        got[i] = !from_dev;
      end
      got_valid = 1;
    end
  end
endmodule // serial_terminal
`default_nettype wire

// >>> sim/async_serial_autobaud_port_tb.sv
// Testbench of the autobaud serial port
`default_nettype none
module async_serial_autobaud_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import serial_port_pkg::*;
  // Short hunt window; must outlast one carriage return at the top rate
  localparam int hunt_cycles = 14000;
  logic mclk, nrst, wake, session_open, hangup, rxd_pin, txd_pin;
  logic tx_valid, tx_ready, rx_valid, got_valid;
  logic [6:0] tx_data, rx_data;
  logic [8:0] got;
  logic [7:0] d;
  rate_sel_t rate_locked;
  logic [31:0] seed;
  int errors, tests_run, n, cyc;
  logic [8:0] exp_q[$];
  logic [6:0] rx_q[$];
  autobaud_serial_port #(.wait_cycles(hunt_cycles)) i_autobaud_serial_port (
    .mclk(mclk), .nrst(nrst), .wake(wake), .session_open(session_open),
    .hangup(hangup), .rate_locked(rate_locked), .rxd_pin(rxd_pin),
    .txd_pin(txd_pin), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid));
  serial_terminal #(.bit_cycles(1302)) i_serial_terminal (.mclk(mclk),
    .from_dev(txd_pin), .to_dev(rxd_pin), .got(got), .got_valid(got_valid));
  always #5 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string what, input logic [8:0] seen,
    input logic [8:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    #1 nrst = 0;
    repeat (6) @(posedge mclk);
    #1 nrst = 1;
    @(posedge mclk);
    #1 wake = 1;
    @(posedge mclk);
    #1 wake = 0;
  endtask
  task automatic send_tx();
    @(posedge mclk);
    #1 seed = lfsr(seed);
    tx_data = seed[6:0];
    tx_valid = 1;
    exp_q.push_back({2'b10, seed[6:0]});
    n = 0;
    do @(negedge mclk); while (!tx_ready && ++n < 20000);
    @(posedge mclk);
    #1 tx_valid = 0;
  endtask
  // ==========
  // Scoreboards
  always @(posedge mclk)
  begin
    if (got_valid === 1'b1)
      check("line", got, exp_q.size() ? exp_q.pop_front() : 9'h1ff);
    if (rx_valid === 1'b1)
      check("rx", {2'b10, rx_data},
        rx_q.size() ? {2'b10, rx_q.pop_front()} : 9'h1ff);
    if (++cyc == 110000)
    begin
      errors++;
      end_sim();
    end
  end
  initial
  begin
    mclk = 0;
    wake = 0;
    tx_valid = 0;
    tx_data = '0;
    seed = 32'h0001_3f78;
    do_reset();
    n = 0;
    while (!hangup && n < hunt_cycles + 1000)
    begin
      @(negedge mclk);
      n++;
    end
    check("hangup", 9'(n > hunt_cycles - 10 && n < hunt_cycles + 10),
      9'h1);
    $display("hangup test done");
    exp_q = '{{1'b1, cr_code}, {1'b1, lf_code}, {1'b1, star_code}};
    do_reset();
    i_serial_terminal.send(cr_code, 0);
    n = 0;
    while (!session_open && n < 60000)
    begin
      @(negedge mclk);
      n++;
    end
    check("prompt", 9'(exp_q.size()), 9'h0);
    check("rate", 9'(rate_locked), 9'(rate_76800));
    $display("lock test done");
    fork
      begin
        send_tx();
        send_tx();
      end
      begin
        seed = lfsr(seed);
        i_serial_terminal.send({1'b1, seed[6:0]}, 1);
        repeat (2600) @(posedge mclk);
        seed = lfsr(seed);
        d = {1'b1, seed[6:0]};
        rx_q.push_back(d[6:0]);
        i_serial_terminal.send(d, 0);
      end
    join
    repeat (3000) @(posedge mclk);
    check("left", 9'(exp_q.size() + rx_q.size()), 9'h0);
    $display("duplex test done");
    end_sim();
  end
endmodule // async_serial_autobaud_port_tb
`default_nettype wire
